//--- src/usb_host_reg_bank.sv
// Host-mode register bank reached through a serial slave port.
`timescale 1ns/10ps
`default_nettype none
`include "usb_host_regs_defines.svh"
module usb_host_reg_bank #(
  parameter logic [7:0] REVISION_ID = 8'hA5  // Arbitrary identification value.
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Serial slave port, mode 0.
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  output logic miso_o,
  // General-purpose pins and interrupt pins.
  input wire logic [7:0] general_input_pin_i,
  output logic [7:0] gpout_o,
  output logic int_o,
  input wire logic [3:0] aux_source_i,
  output logic aux_multiplexed_output_o,
  // Event pulses from the protocol engine.
  input wire logic [7:0] usb_event_i,
  input wire logic [7:0] host_event_i,
  // Host operation request and result.
  input wire logic [7:0] host_result_i,
  output logic host_op_start_o,
  output logic host_op_bus_ctl_o,
  output logic [7:0] host_op_data_o,
  // Configuration seen by the rest of the device.
  output logic [7:0] mode_o
);

  // Serial framing state.
  usb_host_regs_pkg::ser_state_t ser_r, ser_nxt;
  logic sclk_q_r, sclk_q_nxt;  // Previous serial clock level.
  logic [2:0] bit_cnt_r, bit_cnt_nxt;  // Bits of the current byte.
  logic [7:0] rx_r, rx_nxt;  // Receive shifter.
  logic [7:0] tx_r, tx_nxt;  // Transmit shifter; bit 7 drives the output.
  logic [4:0] addr_r, addr_nxt;  // Register addressed by the command.
  logic wr_dir_r, wr_dir_nxt;  // Command direction, high for write.
  // Storage registers.
  logic [7:0] rcv_fifo_r, rcv_fifo_nxt, snd_fifo_r, snd_fifo_nxt;
  logic [7:0] setup_fifo_r, setup_fifo_nxt, rcv_cnt_r, rcv_cnt_nxt;
  logic [7:0] snd_cnt_r, snd_cnt_nxt, usb_flag_r, usb_flag_nxt;
  logic [7:0] usb_en_r, usb_en_nxt, chip_ctl_r, chip_ctl_nxt;
  logic [7:0] proc_ctl_r, proc_ctl_nxt, pin_ctl_r, pin_ctl_nxt;
  logic [3:0] out_low_r, out_low_nxt, out_high_r, out_high_nxt;
  logic [7:0] in_flag_r, in_flag_nxt, in_en_r, in_en_nxt;
  logic [7:0] in_pol_r, in_pol_nxt, host_flag_r, host_flag_nxt;
  logic [7:0] host_en_r, host_en_nxt, mode_r, mode_nxt;
  logic [7:0] per_addr_r, per_addr_nxt, bus_ctl_r, bus_ctl_nxt;
  logic [7:0] xfer_r, xfer_nxt;
  // Interrupt generation.
  logic [7:0] pin_q_r, pin_q_nxt;  // Previous input levels.
  logic pend_q_r, pend_q_nxt;  // Previous main interrupt request.
  logic [11:0] pw_cnt_r, pw_cnt_nxt;  // Remaining pulse cycles.
  // Output flops.
  logic int_nxt, aux_nxt, start_nxt, bus_sel_nxt;
  logic [7:0] op_data_nxt;
  // Combinational helpers.
  logic sclk_rise, sclk_fall, byte_done, wr_fire, host_mode, sep_irq;
  logic usb_pend, host_pend, in_pend, main_pend, second_pend;
  logic [7:0] in_edge, usb_mask, clr;

  // Width in cycles of the edge-mode interrupt pulse for a field code.
  function automatic logic [11:0] pulse_cycles(input logic [1:0] code);
    case (code)
      2'h0: pulse_cycles = 12'(`IRQ_PW0_CYC);
      2'h1: pulse_cycles = 12'(`IRQ_PW1_CYC);
      2'h2: pulse_cycles = 12'(`IRQ_PW2_CYC);
      default: pulse_cycles = 12'(`IRQ_PW3_CYC);
    endcase
  endfunction

  // Read value of a register; counts and peripheral address read 7 bits, host-only registers read zero in peripheral mode.
  function automatic logic [7:0] read_value(input logic [4:0] a);
    logic h;
    h = mode_r[`MODE_HOST_BIT];
    case (a)
      `A_RCV_FIFO: read_value = rcv_fifo_r;
      `A_SND_FIFO: read_value = snd_fifo_r;
      `A_SETUP_FIFO: read_value = setup_fifo_r;
      `A_RCV_COUNT: read_value = rcv_cnt_r & `COUNT_MASK;
      `A_SND_COUNT: read_value = snd_cnt_r & `COUNT_MASK;
      `A_USB_FLAGS: read_value = usb_flag_r;
      `A_USB_ENABLES: read_value = usb_en_r;
      `A_CHIP_CTL: read_value = chip_ctl_r;
      `A_PROC_CTL: read_value = proc_ctl_r;
      `A_PIN_CTL: read_value = pin_ctl_r;
      `A_REVISION: read_value = REVISION_ID;
      `A_PINS_LOW: read_value = {general_input_pin_i[3:0], out_low_r};
      `A_PINS_HIGH: read_value = {general_input_pin_i[7:4], out_high_r};
      `A_IN_FLAGS: read_value = in_flag_r;
      `A_IN_ENABLES: read_value = in_en_r;
      `A_IN_POLARITY: read_value = in_pol_r;
      `A_HOST_FLAGS: read_value = h ? host_flag_r : 8'h00;
      `A_HOST_ENABLES: read_value = h ? host_en_r : 8'h00;
      `A_MODE: read_value = mode_r;
      `A_PERIPH_ADDR: read_value = h ? (per_addr_r & `COUNT_MASK) : 8'h00;
      `A_HOST_BUS_CTL: read_value = h ? bus_ctl_r : 8'h00;
      `A_HOST_XFER: read_value = h ? xfer_r : 8'h00;
      `A_HOST_RESULT: read_value = h ? host_result_i : 8'h00;
      default: read_value = 8'h00;
    endcase
  endfunction

  // Serial clock edges, byte completion and interrupt requests.
  assign sclk_rise = sclk_i & ~sclk_q_r;
  assign sclk_fall = ~sclk_i & sclk_q_r;
  assign byte_done = ~ss_n_i & sclk_rise & (bit_cnt_r == 3'h7);
  assign wr_fire = byte_done & ser_r[2] & wr_dir_r;
  assign host_mode = mode_r[`MODE_HOST_BIT];
  assign usb_mask = host_mode ? `USB_FLAGS_HOST_MASK : 8'hFF;
  assign clr = wr_fire ? rx_nxt : 8'h00;
  // Polarity high takes rising edges, low takes falling edges.
  assign in_edge = (in_pol_r & general_input_pin_i & ~pin_q_r)
                 | (~in_pol_r & ~general_input_pin_i & pin_q_r);
  assign sep_irq = mode_r[`MODE_SEP_IRQ_BIT]
                 & (pin_ctl_r[`PIN_SEL_MSB:`PIN_SEL_LSB] == `AUX_SEL_SEP);
  assign usb_pend = |(usb_flag_r & usb_en_r);
  assign host_pend = host_mode & (|(host_flag_r & host_en_r));
  assign in_pend = |(in_flag_r & in_en_r);
  assign main_pend = proc_ctl_r[`PROC_GIE_BIT]
                   & (usb_pend | host_pend | (in_pend & ~sep_irq));
  assign second_pend = proc_ctl_r[`PROC_GIE_BIT] & in_pend & sep_irq;

  // Next values of all state: framing, registers and interrupt pins.
  always_comb begin
    ser_nxt = ser_r;
    sclk_q_nxt = sclk_i;
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    wr_dir_nxt = wr_dir_r;
    rcv_fifo_nxt = rcv_fifo_r;
    snd_fifo_nxt = snd_fifo_r;
    setup_fifo_nxt = setup_fifo_r;
    rcv_cnt_nxt = rcv_cnt_r;
    snd_cnt_nxt = snd_cnt_r;
    usb_en_nxt = usb_en_r;
    chip_ctl_nxt = chip_ctl_r;
    proc_ctl_nxt = proc_ctl_r;
    pin_ctl_nxt = pin_ctl_r;
    out_low_nxt = out_low_r;
    out_high_nxt = out_high_r;
    in_en_nxt = in_en_r;
    in_pol_nxt = in_pol_r;
    host_en_nxt = host_en_r;
    mode_nxt = mode_r;
    per_addr_nxt = per_addr_r;
    bus_ctl_nxt = bus_ctl_r;
    xfer_nxt = xfer_r;
    start_nxt = 1'b0;
    bus_sel_nxt = host_op_bus_ctl_o;
    op_data_nxt = host_op_data_o;
    // Framing: deselect aborts, select preloads the status byte with full duplex set, zero otherwise.
    case (ser_r)
      usb_host_regs_pkg::SER_IDLE: begin
        if (!ss_n_i) begin
          ser_nxt = usb_host_regs_pkg::SER_CMD;
          bit_cnt_nxt = 3'h0;
          // With full duplex set, host flags (USB flags in peripheral mode) go out while the command byte comes in.
          tx_nxt = pin_ctl_r[`PIN_FDUP_BIT] ? (host_mode ? host_flag_r : usb_flag_r)
                                            : 8'h00;
        end
      end
      usb_host_regs_pkg::SER_CMD, usb_host_regs_pkg::SER_DATA: begin
        if (ss_n_i) begin
          ser_nxt = usb_host_regs_pkg::SER_IDLE;
        end else if (sclk_rise) begin
          rx_nxt = {rx_r[6:0], mosi_i};
          bit_cnt_nxt = 3'(bit_cnt_r + 3'h1);
        end else if (sclk_fall && bit_cnt_r != 3'h0) begin
          // No shift on the fall that follows a fresh load.
          tx_nxt = {tx_r[6:0], 1'b0};
        end
        if (byte_done && ser_r[1]) begin
          // Command byte: latch address and direction, preload read data.
          addr_nxt = rx_nxt[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
          wr_dir_nxt = rx_nxt[`CMD_DIR_BIT];
          tx_nxt = read_value(rx_nxt[`CMD_ADDR_MSB:`CMD_ADDR_LSB]);
          ser_nxt = usb_host_regs_pkg::SER_DATA;
        end else if (byte_done) begin
          // Data bytes repeat on the same register.
          tx_nxt = read_value(addr_r);
        end
      end
      default: begin
        ser_nxt = usb_host_regs_pkg::SER_IDLE;
      end
    endcase
    // Register writes; read-only and unmapped addresses fall to default.
    if (wr_fire) begin
      case (addr_r)
        `A_RCV_FIFO: rcv_fifo_nxt = rx_nxt;
        `A_SND_FIFO: snd_fifo_nxt = rx_nxt;
        `A_SETUP_FIFO: setup_fifo_nxt = rx_nxt;
        `A_RCV_COUNT: rcv_cnt_nxt = rx_nxt & `COUNT_MASK;
        `A_SND_COUNT: snd_cnt_nxt = rx_nxt & `COUNT_MASK;
        `A_USB_ENABLES: usb_en_nxt = rx_nxt & usb_mask;
        `A_CHIP_CTL: chip_ctl_nxt = rx_nxt & (host_mode ? `CHIP_CTL_HOST_MASK : 8'hFF);
        `A_PROC_CTL: proc_ctl_nxt = rx_nxt & `PROC_CTL_MASK;
        `A_PIN_CTL: pin_ctl_nxt = rx_nxt;
        `A_PINS_LOW: out_low_nxt = rx_nxt[3:0];
        `A_PINS_HIGH: out_high_nxt = rx_nxt[3:0];
        `A_IN_ENABLES: in_en_nxt = rx_nxt;
        `A_IN_POLARITY: in_pol_nxt = rx_nxt;
        `A_HOST_ENABLES: host_en_nxt = host_mode ? rx_nxt : host_en_r;
        `A_MODE: mode_nxt = host_mode ? rx_nxt : (rx_nxt & `MODE_PERIPH_MASK);
        `A_PERIPH_ADDR: per_addr_nxt = host_mode ? (rx_nxt & `COUNT_MASK) : per_addr_r;
        `A_HOST_BUS_CTL, `A_HOST_XFER: begin
          if (host_mode) begin
            // Every write launches an operation of the kind just written.
            start_nxt = 1'b1;
            bus_sel_nxt = (addr_r == `A_HOST_BUS_CTL);
            op_data_nxt = rx_nxt;
            if (addr_r == `A_HOST_BUS_CTL) begin
              bus_ctl_nxt = rx_nxt;
            end else begin
              xfer_nxt = rx_nxt;
            end
          end
        end
        default: begin
          // Read-only and clear-only registers store nothing here.
        end
      endcase
    end
    // Clear-only flags: a one clears, a zero keeps, a new event wins.
    usb_flag_nxt = ((usb_flag_r & ~((addr_r == `A_USB_FLAGS) ? clr : 8'h00)) | usb_event_i)
                 & usb_mask;
    host_flag_nxt = host_mode ? ((host_flag_r & ~((addr_r == `A_HOST_FLAGS) ? clr : 8'h00))
                  | host_event_i) : 8'h00;
    in_flag_nxt = (in_flag_r & ~((addr_r == `A_IN_FLAGS) ? clr : 8'h00)) | in_edge;
    pin_q_nxt = general_input_pin_i;
    // Edge mode: a new request starts one pulse of the selected width.
    pend_q_nxt = main_pend;
    pw_cnt_nxt = (pw_cnt_r != 12'h000) ? 12'(pw_cnt_r - 12'h001) : 12'h000;
    if (main_pend && !pend_q_r) begin
      pw_cnt_nxt = pulse_cycles(proc_ctl_r[`PROC_PW_MSB:`PROC_PW_LSB]);
    end
    if (pin_ctl_r[`PIN_LEVEL_BIT]) begin
      int_nxt = ~main_pend;  // Level mode is active low.
    end else begin
      int_nxt = (pw_cnt_nxt != 12'h000) ? pin_ctl_r[`PIN_POSINT_BIT]
                                        : ~pin_ctl_r[`PIN_POSINT_BIT];
    end
    // Auxiliary output turns into the input-pin interrupt when separated.
    aux_nxt = sep_irq ? second_pend
                      : aux_source_i[pin_ctl_r[`PIN_SEL_MSB:`PIN_SEL_LSB]];
  end

  // Registers all state; synchronous reset to defined values.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ser_r <= usb_host_regs_pkg::SER_IDLE;
      {sclk_q_r, bit_cnt_r, rx_r, tx_r, addr_r, wr_dir_r} <= '0;
      {rcv_fifo_r, snd_fifo_r, setup_fifo_r, rcv_cnt_r, snd_cnt_r} <= '0;
      {usb_flag_r, usb_en_r, chip_ctl_r, proc_ctl_r, pin_ctl_r} <= '0;
      {out_low_r, out_high_r, in_flag_r, in_en_r, in_pol_r} <= '0;
      {host_flag_r, host_en_r, mode_r, per_addr_r, bus_ctl_r, xfer_r} <= '0;
      {pin_q_r, pend_q_r, pw_cnt_r} <= '0;
      {miso_o, gpout_o, aux_multiplexed_output_o, mode_o} <= '0;
      {host_op_start_o, host_op_bus_ctl_o, host_op_data_o} <= '0;
      int_o <= 1'b1;
    end else begin
      ser_r <= ser_nxt;
      sclk_q_r <= sclk_q_nxt;
      bit_cnt_r <= ser_nxt[0] ? 3'h0 : bit_cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      wr_dir_r <= wr_dir_nxt;
      {rcv_fifo_r, snd_fifo_r, setup_fifo_r} <= {rcv_fifo_nxt, snd_fifo_nxt, setup_fifo_nxt};
      {rcv_cnt_r, snd_cnt_r} <= {rcv_cnt_nxt, snd_cnt_nxt};
      {usb_flag_r, usb_en_r, chip_ctl_r} <= {usb_flag_nxt, usb_en_nxt, chip_ctl_nxt};
      {proc_ctl_r, pin_ctl_r} <= {proc_ctl_nxt, pin_ctl_nxt};
      {out_low_r, out_high_r} <= {out_low_nxt, out_high_nxt};
      {in_flag_r, in_en_r, in_pol_r} <= {in_flag_nxt, in_en_nxt, in_pol_nxt};
      {host_flag_r, host_en_r, mode_r} <= {host_flag_nxt, host_en_nxt, mode_nxt};
      {per_addr_r, bus_ctl_r, xfer_r} <= {per_addr_nxt, bus_ctl_nxt, xfer_nxt};
      {pin_q_r, pend_q_r, pw_cnt_r} <= {pin_q_nxt, pend_q_nxt, pw_cnt_nxt};
      miso_o <= tx_nxt[7];
      gpout_o <= {out_high_nxt, out_low_nxt};
      int_o <= int_nxt;
      aux_multiplexed_output_o <= aux_nxt;
      mode_o <= mode_nxt;
      host_op_start_o <= start_nxt;
      host_op_bus_ctl_o <= bus_sel_nxt;
      host_op_data_o <= op_data_nxt;
    end
  end

  // Checks on the bank's own behaviour.
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  pulse_width_a: assert property ($rose(main_pend) && !pin_ctl_r[`PIN_LEVEL_BIT]
    |=> pw_cnt_r == pulse_cycles($past(proc_ctl_r[7:6]))) else $error("bad pulse width");
  // With the second pin in use, input flags alone must leave the main pin released.
  sep_irq_pin_a: assert property (sep_irq && pin_ctl_r[`PIN_LEVEL_BIT]
    && !usb_pend && !host_pend |=> int_o) else $error("main pin not released");
  sep_irq_out_a: assert property (sep_irq
    |=> aux_multiplexed_output_o == $past(second_pend)) else $error("aux pin wrong");
  // A write to the second pins register reaches the upper output nibble.
  gpout_map_a: assert property (wr_fire && addr_r == `A_PINS_HIGH
    |=> gpout_o[7:4] == $past(rx_nxt[3:0])) else $error("gpout wrong");
  in_flag_set_a: assert property (in_edge[0] |=> in_flag_r[0]) else $error("lost edge");
  w1c_clear_a: assert property (wr_fire && addr_r == `A_IN_FLAGS && rx_nxt[1]
    && !in_edge[1] |=> !in_flag_r[1]) else $error("flag not cleared");
  w0_keep_a: assert property (wr_fire && addr_r == `A_IN_FLAGS && !rx_nxt[2]
    && in_flag_r[2] |=> in_flag_r[2]) else $error("flag lost");
  host_launch_a: assert property (wr_fire && host_mode && addr_r == `A_HOST_XFER
    |=> host_op_start_o && !host_op_bus_ctl_o ##1 !host_op_start_o)
    else $error("no launch");
  ro_write_a: assert property (wr_fire && addr_r == `A_HOST_RESULT
    |=> !host_op_start_o && $stable(mode_r)) else $error("read-only side effect");
  status_first_a: assert property (ser_r[0] && !ss_n_i && pin_ctl_r[`PIN_FDUP_BIT]
    && host_mode |=> miso_o == $past(host_flag_r[7])) else $error("status byte missing");
  irq_gate_a: assert property (pin_ctl_r[`PIN_LEVEL_BIT] && !proc_ctl_r[`PROC_GIE_BIT]
    && $stable(pin_ctl_r) |=> int_o) else $error("ungated interrupt");

endmodule  // usb_host_reg_bank
`default_nettype wire

//--- src/usb_host_regs_defines.svh
// Offsets, field positions, reset values and timing counts of the register bank.
`ifndef USB_HOST_REGS_DEFINES_SVH
`define USB_HOST_REGS_DEFINES_SVH
// Register addresses as carried in the command byte.
`define A_RCV_FIFO 5'h01
`define A_SND_FIFO 5'h02
`define A_SETUP_FIFO 5'h04
`define A_RCV_COUNT 5'h06
`define A_SND_COUNT 5'h07
`define A_USB_FLAGS 5'h0D
`define A_USB_ENABLES 5'h0E
`define A_CHIP_CTL 5'h0F
`define A_PROC_CTL 5'h10
`define A_PIN_CTL 5'h11
`define A_REVISION 5'h12
`define A_PINS_LOW 5'h14
`define A_PINS_HIGH 5'h15
`define A_IN_FLAGS 5'h16
`define A_IN_ENABLES 5'h17
`define A_IN_POLARITY 5'h18
`define A_HOST_FLAGS 5'h19
`define A_HOST_ENABLES 5'h1A
`define A_MODE 5'h1B
`define A_PERIPH_ADDR 5'h1C
`define A_HOST_BUS_CTL 5'h1D
`define A_HOST_XFER 5'h1E
`define A_HOST_RESULT 5'h1F
// Command byte fields.
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 3
`define CMD_DIR_BIT 1
// Field positions.
`define MODE_HOST_BIT 0
`define MODE_SEP_IRQ_BIT 4
`define PROC_GIE_BIT 0
`define PROC_PW_MSB 7
`define PROC_PW_LSB 6
`define PIN_FDUP_BIT 4
`define PIN_LEVEL_BIT 3
`define PIN_POSINT_BIT 2
`define PIN_SEL_MSB 1
`define PIN_SEL_LSB 0
`define AUX_SEL_SEP 2'h2
// Bits that exist in host mode for shared registers, and the 7 bits kept in counts and peripheral address.
`define USB_FLAGS_HOST_MASK 8'h61
`define CHIP_CTL_HOST_MASK 8'h30
`define COUNT_MASK 8'h7F
// Bits kept by a write to processor control, and by a mode write in peripheral mode; register reset value.
`define PROC_CTL_MASK 8'hC1
`define MODE_PERIPH_MASK 8'h11
`define REG_RESET 8'h00
// Interrupt pulse widths in ns and their cycle counts.
`define CLK_PERIOD_PS 5000
`define IRQ_PW0_NS 10600
`define IRQ_PW1_NS 5300
`define IRQ_PW2_NS 2600
`define IRQ_PW3_NS 1300
`define IRQ_PW0_CYC ((`IRQ_PW0_NS * 1000) / `CLK_PERIOD_PS)
`define IRQ_PW1_CYC ((`IRQ_PW1_NS * 1000) / `CLK_PERIOD_PS)
`define IRQ_PW2_CYC ((`IRQ_PW2_NS * 1000) / `CLK_PERIOD_PS)
`define IRQ_PW3_CYC ((`IRQ_PW3_NS * 1000) / `CLK_PERIOD_PS)
`endif

//--- src/usb_host_regs_pkg.sv
// Types shared by the register bank.
package usb_host_regs_pkg;
  // Serial framing states, one-hot.
  typedef enum logic [2:0] {
    SER_IDLE = 3'h1,
    SER_CMD = 3'h2,
    SER_DATA = 3'h4
  } ser_state_t;
endpackage

//--- testbench/spi_master_model.sv
// Serial master model that drives the register port of the bank.
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  // Clock and returned data.
  input wire logic mclk_i,
  input wire logic miso_i,
  // Serial lines driven by the master.
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o
);
  // Lines idle: clock low, select high.
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end
  // Shifts one byte MSB first; four mclk per level keeps sclk well below mclk/4.
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
  endtask
  // One frame: command byte then one data byte at the same address.
  task automatic frame(input logic [4:0] a, input logic w, input logic [7:0] wd,
                       output logic [7:0] st, output logic [7:0] rd);
    @(negedge mclk_i);
    ss_n_o = 1'b0;
    shift({a, 1'b0, w, 1'b0}, st);
    shift(wd, rd);
    repeat (4) @(negedge mclk_i);
    // A released data line does not keep its last value.
    mosi_o = ~mosi_o;
    ss_n_o = 1'b1;
    repeat (4) @(negedge mclk_i);
  endtask
endmodule // spi_master_model
`default_nettype wire

//--- testbench/usb_host_reg_bank_tb.sv
// Self-checking bench for the host-mode register bank.
`timescale 1ns/10ps
`default_nettype none
`include "usb_host_regs_defines.svh"
module usb_host_reg_bank_tb;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary identification value.
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sclk, mosi, ss_n, miso, int_o, aux_out, op_start, op_bc;
  logic [7:0] gp_in = 8'h00;
  logic [3:0] aux_src = 4'h0;
  logic [7:0] usb_ev = 8'h00;
  logic [7:0] host_ev = 8'h00;
  logic [7:0] host_res = 8'h00;
  logic [7:0] gpout, op_data, mode;
  logic [7:0] st, rd, v, old, pol, nw, ex, c;
  logic p; // Active level of the edge-mode pulse under test.
  logic [4:0] ra [15] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h07, 5'h0E, 5'h0F, 5'h10,
                          5'h11, 5'h17, 5'h18, 5'h1A, 5'h1C, 5'h03, 5'h08};
  logic [7:0] rm [15] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h61, 8'h30, 8'hC1,
                          8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h00};
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int starts = 0;
  int n, k, s0;
  // Clock at 200 MHz.
  always #2.5 mclk_i = ~mclk_i;
  usb_host_reg_bank #(.REVISION_ID(REV)) usb_host_reg_bank_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n),
    .miso_o(miso), .general_input_pin_i(gp_in), .gpout_o(gpout), .int_o(int_o),
    .aux_source_i(aux_src), .aux_multiplexed_output_o(aux_out), .usb_event_i(usb_ev),
    .host_event_i(host_ev), .host_result_i(host_res), .host_op_start_o(op_start),
    .host_op_bus_ctl_o(op_bc), .host_op_data_o(op_data), .mode_o(mode));
  spi_master_model spi_master_model_inst (
    .mclk_i(mclk_i), .miso_i(miso), .sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n));
  // Compares one result and reports a difference at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    spi_master_model_inst.frame(a, 1'b1, d, st, rd);
  endtask
  task automatic rdb(input logic [4:0] a);
    spi_master_model_inst.frame(a, 1'b0, 8'h00, st, rd);
  endtask
  // Flags an input sets for a given polarity, old and new level.
  function automatic logic [7:0] edges(input logic [7:0] p, input logic [7:0] o,
                                       input logic [7:0] nv);
    return (p & ~o & nv) | (~p & o & ~nv);
  endfunction
  // Pulse width in cycles for each width code at 5 ns.
  function automatic int pw_cyc(input logic [1:0] code);
    case (code)
      2'h0: return 2120;
      2'h1: return 1060;
      2'h2: return 520;
      default: return 260;
    endcase
  endfunction
  // Counts launch pulses and cuts a hang short.
  always @(posedge mclk_i) begin
    cyc++;
    if (op_start === 1'b1) begin
      starts++;
    end
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hc265));
    aux_src = 4'($urandom());
    gp_in = 8'($urandom());
    host_res = 8'($urandom());
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    wr(`A_REVISION, ~REV);
    rdb(`A_REVISION);
    chk(rd, REV);
    wr(`A_PERIPH_ADDR, 8'h55);
    wr(`A_MODE, 8'hFE);
    chk(mode, 8'h10);
    wr(`A_MODE, 8'h01);
    chk(mode, 8'h01);
    rdb(`A_PERIPH_ADDR);
    chk(rd, 8'h00);
    // Random write and read back, unused bits and unmapped places read zero.
    foreach (ra[i]) begin
      v = 8'($urandom());
      wr(ra[i], v);
      rdb(ra[i]);
      chk(rd, v & rm[i]);
    end
    v = 8'($urandom());
    c = 8'($urandom());
    wr(`A_PINS_LOW, v);
    wr(`A_PINS_HIGH, c);
    chk(gpout, {c[3:0], v[3:0]});
    rdb(`A_PINS_HIGH);
    chk(rd, {gp_in[7:4], c[3:0]});
    // Input edges with random polarity, bit 0 always set.
    old = gp_in;
    nw = 8'($urandom());
    pol = 8'($urandom());
    nw[0] = ~old[0];
    pol[0] = ~old[0];
    wr(`A_IN_POLARITY, pol);
    wr(`A_IN_FLAGS, 8'hFF);
    @(negedge mclk_i);
    gp_in = nw;
    ex = edges(pol, old, nw);
    rdb(`A_IN_FLAGS);
    chk(rd, ex);
    c = 8'($urandom()) & 8'hFE;
    wr(`A_IN_FLAGS, c);
    rdb(`A_IN_FLAGS);
    chk(rd, ex & ~c);
    // Input interrupt on the main pin, then on the second pin.
    wr(`A_IN_ENABLES, 8'hFF);
    wr(`A_PIN_CTL, 8'h0A);
    wr(`A_PROC_CTL, 8'h00);
    chk(int_o, 1'b1);
    chk(aux_out, aux_src[2]);
    wr(`A_PROC_CTL, 8'h01);
    chk(int_o, 1'b0);
    wr(`A_MODE, 8'h11);
    chk(int_o, 1'b1);
    chk(aux_out, 1'b1);
    wr(`A_MODE, 8'h01);
    wr(`A_IN_ENABLES, 8'h00);
    // Host flags appear as the status byte in full duplex.
    wr(`A_HOST_ENABLES, 8'h00);
    v = 8'($urandom()) | 8'h01;
    @(negedge mclk_i);
    host_ev = v;
    usb_ev = 8'hFF;
    @(negedge mclk_i);
    host_ev = 8'h00;
    usb_ev = 8'h00;
    wr(`A_PIN_CTL, 8'h18);
    wr(`A_USB_ENABLES, 8'h00);
    rdb(`A_HOST_FLAGS);
    chk(st, v);
    chk(int_o, 1'b1);
    rdb(`A_USB_FLAGS);
    chk(rd, 8'h61);
    wr(`A_HOST_ENABLES, 8'h01);
    chk(int_o, 1'b0);
    wr(`A_USB_FLAGS, 8'hFF);
    wr(`A_HOST_FLAGS, 8'hFF);
    // Edge mode pulse width for every code, both pulse polarities.
    for (int code = 0; code < 4; code++) begin
      p = 1'(code);
      wr(`A_PIN_CTL, {5'h00, p, 2'h0});
      wr(`A_PROC_CTL, {2'(code), 6'h01});
      // A pulse started earlier in level mode may still run; let it end first.
      k = 0;
      while (int_o !== ~p && k < 3000) begin
        @(negedge mclk_i);
        k++;
      end
      @(negedge mclk_i);
      host_ev = 8'h01;
      @(negedge mclk_i);
      host_ev = 8'h00;
      k = 0;
      while (int_o !== p && k < 50) begin
        @(negedge mclk_i);
        k++;
      end
      n = 0;
      while (int_o === p && n < 3000) begin
        @(negedge mclk_i);
        n++;
      end
      chk(16'(n), 16'(pw_cyc(2'(code))));
      wr(`A_HOST_FLAGS, 8'h01);
    end
    // Launches, read-only result and refusal in peripheral mode.
    s0 = starts;
    v = 8'($urandom());
    c = 8'($urandom());
    wr(`A_HOST_XFER, v);
    chk(16'(starts), 16'(s0 + 1));
    chk({op_bc, op_data}, {1'b0, v});
    wr(`A_HOST_BUS_CTL, c);
    chk({op_bc, op_data}, {1'b1, c});
    wr(`A_HOST_RESULT, ~host_res);
    rdb(`A_HOST_RESULT);
    chk(rd, host_res);
    wr(`A_MODE, 8'h00);
    wr(`A_HOST_XFER, v);
    chk(16'(starts), 16'(s0 + 2));
    finish_test();
  end
endmodule // usb_host_reg_bank_tb
`default_nettype wire
